// ### hdl/fsg_host_ctrl.v
// host sequencer driving a parallel flash's strobes, address, data and protection pins
// assumes the flash pins are synchronous to i_ref_clk; high voltages are driven by level shifters
`timescale 1ns/10ps
`include "fsg_defs.vh"
// What the document requires
// RQ1 - protected sectors refuse program and erase
// RQ2 - unprotected sector accepts program and erase again
// RQ3 - reset pin high voltage for protect changes
// RQ4 - protect other sectors before unprotecting one; temporary unprotect here protects no sector first
// RQ5 - equipment method needs high voltage pins
// RQ6 - top boot: high codes are boot sectors
// RQ7 - bottom boot: low codes are boot sectors
// RQ8 - write-protect low locks two outer sectors
// RQ9 - write-protect high: outer sectors follow status
// RQ10 - acceleration voltage gives two-cycle bypass programming
// RQ11 - raise acceleration only from read mode
// RQ12 - reset high voltage temporarily unprotects sectors
// RQ13 - stable address leads to automatic sleep
// RQ14 - low supply blocks all write cycles
// RQ15 - strobe pulses under 5 ns ignored
// RQ16 - write needs select, write low, output high
// RQ17 - all three strobes low is a read
// RQ18 - power-up locks out writes
// RQ19 - program and erase need unlock cycles
// RQ20 - host holds control pins safe above lockout
// RQ21 - address at later fall, data earlier rise
// RQ22 - reset low aborts and returns to read
// RQ23 - protected target completes without change
// RQ24 - lockout ends after strobe seen high
module fsg_host_ctrl
#(
   parameter HV_SETTLE_CYC = `FSG_HV_SETTLE_CYC
)
(
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_req, // one-cycle request pulse
   input wire [2:0] i_op, // operation code
   input wire [19:0] i_addr, // target word address
   input wire [15:0] i_wdata, // program data
   input wire i_top_boot, // 1: top boot variant
   input wire i_supply_ok, // supply above supply_lockout_threshold
   input wire [15:0] i_dq_in, // flash data pins, input side
   output reg o_busy,
   output reg o_done, // one-cycle pulse
   output reg o_refused, // one-cycle pulse with o_done
   output reg [15:0] o_rdata,
   output reg [19:0] o_fl_addr,
   output reg [15:0] o_dq_out,
   output reg o_dq_oe, // high while host drives the data pins
   output reg o_fl_ce_n,
   output reg o_fl_we_n,
   output reg o_fl_oe_n,
   output reg o_fl_reset_n, // logic reset to the flash
   output reg o_rst_id_hv_en, // identification_high_voltage on reset pin
   output reg o_wp_n, // write-protect level
   output reg o_acc_hv_en // acceleration_high_voltage on the protect pin
);
   // states, one-hot
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_HV = 7'h02;
   localparam [6:0] ST_SETUP = 7'h04;
   localparam [6:0] ST_WLOW = 7'h08;
   localparam [6:0] ST_WHIGH = 7'h10;
   localparam [6:0] ST_READ = 7'h20;
   localparam [6:0] ST_DROP = 7'h40;

   reg [6:0] state_q; // sequencer state
   reg [2:0] op_q; // latched operation
   reg [19:0] pa_q; // latched target address
   reg [15:0] pd_q; // latched data
   reg [2:0] step_q; // bus cycle number in the sequence
   reg [12:0] cnt_q; // delay counter, wide enough for the settle time
   reg pwr_lock_q; // power-up write lockout
   reg strobe_seen_q; // strobes observed high after power-up
   wire [19:0] rom_addr; // table address
   wire [15:0] rom_data; // table data
   wire rom_last; // final cycle of the sequence
   reg [6:0] state_d;
   reg last_q; // bus cycle now on the pins is the final one
   // pulse counts kept 32 bits wide; the counter takes their low bits
   localparam [31:0] RD_CYC = `FSG_RD_CYC;
   localparam [31:0] WE_LOW_CYC = `FSG_WE_LOW_CYC;
   localparam [31:0] WE_HIGH_CYC = `FSG_WE_HIGH_CYC;

   // boot sector select: true for the two outermost 8K sectors
   function outer_boot;
      input [7:0] sel;
      input top;
      begin
         if (top)
            outer_boot = (sel >= 8'hFE); // RQ6 RQ8
         else
            outer_boot = (sel <= 8'h01); // RQ7 RQ8
      end
   endfunction

   fsg_step_rom u_rom
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_op(op_q),
      .i_step(step_q),
      .i_pa(pa_q),
      .i_pd(pd_q),
      .o_addr(rom_addr),
      .o_data(rom_data),
      .o_last(rom_last)
   );

   // next state
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (i_req && i_supply_ok && !pwr_lock_q) // RQ14 RQ18
               state_d = (i_op == `FSG_OP_READ) ? ST_READ : ST_HV;
         ST_HV:
            if (cnt_q == 13'h0000)
               state_d = (op_q == `FSG_OP_TEMP_UNPROT) ? ST_DROP : ST_SETUP;
         ST_SETUP:
            state_d = ST_WLOW;
         ST_WLOW:
            if (cnt_q == 13'h0000)
               state_d = ST_WHIGH;
         ST_WHIGH:
            if (cnt_q == 13'h0000)
               state_d = last_q ? ST_DROP : ST_SETUP;
         ST_READ:
            if (cnt_q == 13'h0000)
               state_d = ST_IDLE;
         ST_DROP:
            if (cnt_q == 13'h0000)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
      // low supply aborts any sequence in flight
      if (!i_supply_ok)
         state_d = ST_IDLE; // RQ14 RQ20
   end

   // power-up lockout: held until strobes have been seen high
   always @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pwr_lock_q <= 1'b1;
         strobe_seen_q <= 1'b0;
      end
      else
      begin
         strobe_seen_q <= o_fl_we_n & o_fl_ce_n;
         if (!i_supply_ok)
            pwr_lock_q <= 1'b1; // RQ14
         else if (strobe_seen_q)
            pwr_lock_q <= 1'b0; // RQ18 RQ24
      end
   end

   // main sequencer registers
   always @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= ST_IDLE;
         op_q <= 3'h0;
         pa_q <= 20'h00000;
         pd_q <= 16'h0000;
         step_q <= 3'h0;
         last_q <= 1'b0;
         cnt_q <= 13'h0000;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_refused <= 1'b0;
         o_rdata <= 16'h0000;
         o_fl_addr <= 20'h00000;
         o_dq_out <= 16'h0000;
         o_dq_oe <= 1'b0;
         o_fl_ce_n <= 1'b1; // RQ20
         o_fl_we_n <= 1'b1; // RQ20
         o_fl_oe_n <= 1'b1;
         o_fl_reset_n <= 1'b0; // RQ22
         o_rst_id_hv_en <= 1'b0;
         o_wp_n <= 1'b0; // RQ8
         o_acc_hv_en <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         o_done <= 1'b0;
         o_refused <= 1'b0;
         o_fl_reset_n <= i_supply_ok; // RQ22
         if (cnt_q != 13'h0000)
            cnt_q <= cnt_q - 13'h0001;
         case (state_q)
            ST_IDLE:
            begin
               o_fl_ce_n <= 1'b1;
               o_fl_we_n <= 1'b1;
               o_fl_oe_n <= 1'b1;
               o_dq_oe <= 1'b0;
               step_q <= 3'h0;
               if (i_req)
               begin
                  op_q <= i_op;
                  pa_q <= i_addr;
                  pd_q <= i_wdata;
                  o_busy <= (state_d != ST_IDLE);
                  if (state_d == ST_IDLE)
                  begin
                     // lockout or low supply: refused at once
                     o_done <= 1'b1;
                     o_refused <= 1'b1; // RQ14 RQ18
                  end
                  else if (i_op == `FSG_OP_READ)
                  begin
                     // all-low strobes avoided; plain read cycle
                     o_fl_addr <= i_addr;
                     o_fl_ce_n <= 1'b0; // RQ17
                     o_fl_oe_n <= 1'b0;
                     cnt_q <= RD_CYC[12:0]; // RQ13
                  end
                  else
                  begin
                     // outer boot sectors unlocked only for a write aimed there; all else keeps the lock
                     o_wp_n <= outer_boot(i_addr[`FSG_SEL_HI:`FSG_SEL_LO], i_top_boot); // RQ8 RQ9
                     // temporary unprotect opens every group at once except the outer boot groups when the target is outside them (o_wp_n stays low), so no group is protected first
                     o_rst_id_hv_en <= (i_op == `FSG_OP_TEMP_UNPROT); // RQ3 RQ4 RQ12
                     o_acc_hv_en <= (i_op == `FSG_OP_ACCEL_PROG); // RQ10 RQ11
                     cnt_q <= HV_SETTLE_CYC[12:0];
                  end
               end
            end
            ST_SETUP:
            begin
               // address and data set before the strobes fall; table steps on now because its
               // word is registered, so the next cycle's word is ready by the next setup
               o_fl_addr <= rom_addr; // RQ21
               o_dq_out <= rom_data; // RQ19
               last_q <= rom_last;
               step_q <= step_q + 3'h1;
               o_dq_oe <= 1'b1;
               // output enable only ever at logic levels: the equipment method is never used
               o_fl_oe_n <= 1'b1; // RQ5 RQ16
               cnt_q <= WE_LOW_CYC[12:0]; // RQ15
            end
            ST_WLOW:
            begin
               o_fl_ce_n <= (state_d == ST_WHIGH);
               o_fl_we_n <= (state_d == ST_WHIGH); // RQ16 RQ21
               if (state_d == ST_WHIGH)
                  cnt_q <= WE_HIGH_CYC[12:0];
            end
            ST_WHIGH:
            begin
               if (state_d == ST_DROP)
               begin
                  o_dq_oe <= 1'b0;
                  cnt_q <= HV_SETTLE_CYC[12:0];
                  o_acc_hv_en <= 1'b0; // RQ10
               end
            end
            ST_HV:
            begin
               if (state_d == ST_DROP)
                  cnt_q <= HV_SETTLE_CYC[12:0];
            end
            ST_READ:
            begin
               if (state_d == ST_IDLE)
               begin
                  o_rdata <= i_dq_in;
                  o_fl_ce_n <= 1'b1;
                  o_fl_oe_n <= 1'b1;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end
            end
            ST_DROP:
            begin
               if (state_d == ST_IDLE)
               begin
                  // high voltage removed: sectors protected again
                  o_rst_id_hv_en <= 1'b0; // RQ12
                  o_wp_n <= 1'b0; // RQ8
                  o_busy <= 1'b0;
                  o_done <= 1'b1; // RQ23
               end
            end
            default:
            begin
               o_busy <= 1'b0;
            end
         endcase
         // supply loss: release strobes and high voltages at once
         if (!i_supply_ok)
         begin
            o_fl_ce_n <= 1'b1; // RQ14 RQ20
            o_fl_we_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_dq_oe <= 1'b0;
            o_rst_id_hv_en <= 1'b0;
            o_acc_hv_en <= 1'b0;
            o_wp_n <= 1'b0; // RQ8
            o_busy <= 1'b0;
         end
      end
   end
endmodule // fsg_host_ctrl

// ### hdl/fsg_step_rom.v
// fixed sequence table: bus cycle number to address and data for each operation
// assumes the caller supplies program address and data for the last cycle
`timescale 1ns/10ps
module fsg_step_rom
(
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire [2:0] i_op,
   input wire [2:0] i_step,
   input wire [19:0] i_pa,
   input wire [15:0] i_pd,
   output reg [19:0] o_addr,
   output reg [15:0] o_data,
   output reg o_last
);
`include "fsg_defs.vh"
   reg [19:0] addr_d; // next table address
   reg [15:0] data_d; // next table data
   reg last_d; // marks the final cycle of the sequence

   // table lookup; registered so the pins see a clean word
   always @*
   begin
      addr_d = i_pa;
      data_d = i_pd;
      last_d = 1'b1;
      if (i_op == `FSG_OP_ACCEL_PROG)
      begin
         // unlock bypass: two cycles, no unlock prefix
         if (i_step == 3'h0)
         begin
            addr_d = `FSG_UNLOCK_A1;
            data_d = `FSG_CMD_PROG;
            last_d = 1'b0;
         end
      end
      else
      begin
         case (i_step)
            3'h0, 3'h3:
            begin
               addr_d = `FSG_UNLOCK_A1;
               data_d = `FSG_UNLOCK_D1;
               last_d = 1'b0;
            end
            3'h1, 3'h4:
            begin
               addr_d = `FSG_UNLOCK_A2;
               data_d = `FSG_UNLOCK_D2;
               last_d = 1'b0;
            end
            3'h2:
            begin
               addr_d = `FSG_UNLOCK_A1;
               data_d = (i_op == `FSG_OP_ERASE) ? `FSG_CMD_ERASE : `FSG_CMD_PROG;
               last_d = 1'b0;
            end
            default:
            begin
               // last cycle: program word, or sector erase at the sector
               if (i_op == `FSG_OP_ERASE)
                  data_d = `FSG_CMD_SECT_ERASE;
            end
         endcase
         // program ends after four cycles
         if (i_op != `FSG_OP_ERASE && i_step == 3'h3)
         begin
            addr_d = i_pa;
            data_d = i_pd;
            last_d = 1'b1;
         end
      end
   end

   // registered read data
   always @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_addr <= 20'h00000;
         o_data <= 16'h0000;
         o_last <= 1'b0;
      end
      else
      begin
         o_addr <= addr_d;
         o_data <= data_d;
         o_last <= last_d;
      end
   end
endmodule // fsg_step_rom

// ### inc/fsg_defs.vh
// constants for the host-side flash protection sequencer
// assumes a 100 MHz reference clock and a parallel flash with separate strobes
`ifndef FSG_DEFS_VH
`define FSG_DEFS_VH
// clock period in ns
`define FSG_CLK_NS 10
// write strobe low time, ns (least time, rounded up)
`define FSG_WE_LOW_NS 50
`define FSG_WE_LOW_CYC ((`FSG_WE_LOW_NS + `FSG_CLK_NS - 1) / `FSG_CLK_NS)
// write strobe high time between cycles, ns
`define FSG_WE_HIGH_NS 30
`define FSG_WE_HIGH_CYC ((`FSG_WE_HIGH_NS + `FSG_CLK_NS - 1) / `FSG_CLK_NS)
// glitch filter figure, ns; strobe pulses are kept longer than this
`define FSG_GLITCH_NS 5
// read access time plus the sleep margin, ns
`define FSG_ACC_NS 90
`define FSG_SLEEP_NS 30
`define FSG_RD_CYC ((`FSG_ACC_NS + `FSG_SLEEP_NS + `FSG_CLK_NS - 1) / `FSG_CLK_NS)
// settle time after a high-voltage pin change, ns
`define FSG_HV_SETTLE_NS 4000
`define FSG_HV_SETTLE_CYC ((`FSG_HV_SETTLE_NS + `FSG_CLK_NS - 1) / `FSG_CLK_NS)
// command codes and unlock addresses, word mode
`define FSG_UNLOCK_A1 20'h00555
`define FSG_UNLOCK_A2 20'h002AA
`define FSG_UNLOCK_D1 16'h00AA
`define FSG_UNLOCK_D2 16'h0055
`define FSG_CMD_PROG 16'h00A0
`define FSG_CMD_ERASE 16'h0080
`define FSG_CMD_SECT_ERASE 16'h0030
`define FSG_CMD_RESET 16'h00F0
// sector select field position within the address
`define FSG_SEL_HI 19
`define FSG_SEL_LO 12
// boot sector codes for each variant
`define FSG_TOP_BOOT_BASE 8'hF8
`define FSG_BOT_BOOT_LAST 8'h07
// operation codes on the user port
`define FSG_OP_PROG 3'h1
`define FSG_OP_ERASE 3'h2
`define FSG_OP_READ 3'h3
`define FSG_OP_TEMP_UNPROT 3'h4
`define FSG_OP_ACCEL_PROG 3'h5
`endif

// ### tb/fsg_flash_model.sv
// behavioural parallel flash: unlock decode, sector protection, boot lock, bypass
// assumes protection bits are preset by the bench; groups are kept per select code
`timescale 1ns/10ps
module fsg_flash_model
(
   input wire i_top_boot,
   input wire [19:0] i_addr,
   input wire [15:0] i_dq,
   input wire i_ce_n,
   input wire i_we_n,
   input wire i_oe_n,
   input wire i_reset_n,
   input wire i_id_hv,
   input wire i_wp_n,
   input wire i_acc_hv,
   output wire [15:0] o_dq
);
   logic [15:0] mem [logic [19:0]]; // sparse, unwritten words read erased
   logic [255:0] prot = '0; // protection bit per select code
   logic [2:0] st = 3'h0; // unlock sequence position
   logic lock = 1'b1; // power-up write lockout
   logic armed = 1'b0; // a write cycle is open
   logic [19:0] la; // latched write address
   realtime t0; // start of the write pulse
   function automatic logic [15:0] rd(input logic [19:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   // unselected bus shows the inverse, so stale data never passes
   assign o_dq = (!i_ce_n && !i_oe_n && i_reset_n) ? rd(i_addr) : ~rd(i_addr);
   // may this sector change now
   function automatic logic open(input logic [7:0] s);
      logic outer;
      outer = i_top_boot ? (s >= 8'hFE) : (s <= 8'h01);
      if (i_acc_hv)
         return 1'b1;
      if (!i_wp_n && outer)
         return 1'b0;
      return !prot[s] || i_id_hv;
   endfunction
   // one accepted bus write through the command sequence
   task automatic step(input logic [19:0] a, input logic [15:0] d);
      logic u1;
      logic u2;
      u1 = a == 20'h00555;
      u2 = a == 20'h002AA;
      case (st)
         3'h0: st = (i_acc_hv && d == 16'h00A0) ? 3'h3 : ((u1 && d == 16'h00AA) ? 3'h1 : 3'h0);
         3'h1: st = (u2 && d == 16'h0055) ? 3'h2 : 3'h0;
         3'h2: st = (u1 && d == 16'h00A0) ? 3'h3 : ((u1 && d == 16'h0080) ? 3'h4 : 3'h0);
         3'h3:
         begin
            if (open(a[19:12]))
               mem[a] = rd(a) & d;
            st = 3'h0;
         end
         3'h4: st = (u1 && d == 16'h00AA) ? 3'h5 : 3'h0;
         3'h5: st = (u2 && d == 16'h0055) ? 3'h6 : 3'h0;
         default:
         begin
            if (d == 16'h0030 && open(a[19:12]))
               foreach (mem[k])
                  if (k[19:12] == a[19:12])
                     mem[k] = 16'hFFFF;
            st = 3'h0;
         end
      endcase
   endtask
   // reset or low supply drops everything and locks writes
   always @(negedge i_reset_n)
   begin
      lock = 1'b1;
      st = 3'h0;
   end
   // lockout ends only if a strobe is already high
   always @(posedge i_reset_n)
      lock = !(i_we_n || i_ce_n);
   // address at the later fall
   always @(negedge i_we_n or negedge i_ce_n)
   begin
      if (!i_we_n && !i_ce_n && i_oe_n && i_reset_n)
      begin
         la = i_addr;
         t0 = $realtime;
         armed = 1'b1;
      end
   end
   // data at the earlier rise; short pulses are noise
   always @(posedge i_we_n or posedge i_ce_n)
   begin
      if (armed && !lock && $realtime - t0 >= 5.0)
         step(la, i_dq);
      armed = 1'b0;
      if (i_reset_n === 1'b1)
         lock = 1'b0;
   end
endmodule // fsg_flash_model

// ### tb/fsg_host_asserts.sv
// checker for the flash host sequencer: strobe levels, pulse lengths, gating
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module fsg_host_asserts
(
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_req,
   input wire i_supply_ok,
   input wire o_busy,
   input wire o_done,
   input wire o_refused,
   input wire [19:0] o_fl_addr,
   input wire [15:0] o_dq_out,
   input wire o_dq_oe,
   input wire o_fl_ce_n,
   input wire o_fl_we_n,
   input wire o_fl_oe_n,
   input wire o_fl_reset_n,
   input wire o_rst_id_hv_en,
   input wire o_acc_hv_en
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   // a write pulse must outlast the glitch filter by a wide margin
   sequence s_we_low;
      !o_fl_we_n [*5];
   endsequence
   // recovery between bus cycles
   sequence s_we_high;
      o_fl_we_n [*3];
   endsequence
   chk_write_levels: assert property (!o_fl_we_n |-> !o_fl_ce_n && o_fl_oe_n && o_dq_oe)
      else $error("write strobe with bad select or output levels");
   chk_no_mixed_read: assert property (!o_fl_oe_n |-> o_fl_we_n && !o_dq_oe)
      else $error("read overlaps a write or a data drive");
   chk_we_low_len: assert property ($fell(o_fl_we_n) |-> s_we_low)
      else $error("write pulse too short");
   chk_we_high_len: assert property ($rose(o_fl_we_n) && o_busy |-> s_we_high)
      else $error("write recovery too short");
   chk_bus_hold: assert property (!o_fl_we_n && !$fell(o_fl_we_n) |-> $stable(o_fl_addr) && $stable(o_dq_out))
      else $error("address or data moved during write pulse");
   chk_lock_quiet: assert property ($rose(i_rst_n) |-> o_fl_we_n && o_fl_ce_n ##1 o_fl_we_n)
      else $error("strobe active right after reset");
   chk_low_supply: assert property (i_req && !o_busy && !i_supply_ok |=> o_done && o_refused)
      else $error("request in low supply not refused");
   chk_reset_quiet: assert property (!o_fl_reset_n |-> o_fl_we_n && !o_acc_hv_en)
      else $error("write or acceleration while flash held in reset");
   chk_hv_exclusive: assert property (o_acc_hv_en |-> !o_rst_id_hv_en && o_busy)
      else $error("acceleration voltage outside its operation");
   chk_refuse_pulse: assert property (o_refused |-> o_done ##1 !o_done)
      else $error("refusal not a single done pulse");
endmodule // fsg_host_asserts

bind fsg_host_ctrl fsg_host_asserts u_fsg_host_asserts (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_req(i_req), .i_supply_ok(i_supply_ok), .o_busy(o_busy), .o_done(o_done), .o_refused(o_refused),
   .o_fl_addr(o_fl_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_fl_ce_n(o_fl_ce_n),
   .o_fl_we_n(o_fl_we_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_reset_n(o_fl_reset_n),
   .o_rst_id_hv_en(o_rst_id_hv_en), .o_acc_hv_en(o_acc_hv_en));

// ### tb/tb_top.sv
// bench for the flash host sequencer against the behavioural flash
// assumes default pulse timing and a short high-voltage settle
`timescale 1ns/10ps
`include "fsg_defs.vh"
module tb_top;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_req = 1'b0;
   logic [2:0] i_op = 3'h0;
   logic [19:0] i_addr = 20'h00000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_top_boot = 1'b1;
   logic i_supply_ok = 1'b1;
   wire busy, done, refused, dq_oe, ce_n, we_n, oe_n, fl_rst_n, id_hv, wp_n, acc_hv;
   wire [15:0] rdata, dq_out, dq_in;
   wire [19:0] fl_addr;
   int err_total = 0;
   int checks = 0;
   logic rf; // refusal seen with the last done
   logic hv_seen = 1'b0;
   logic acc_seen = 1'b0;
   always #5 i_ref_clk = ~i_ref_clk;
   // remember high-voltage pulses between checks
   always @(posedge i_ref_clk)
   begin
      if (id_hv)
         hv_seen <= 1'b1;
      if (acc_hv)
         acc_seen <= 1'b1;
   end
   fsg_host_ctrl #(.HV_SETTLE_CYC(4)) u_fsg_host_ctrl (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_req(i_req), .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .i_top_boot(i_top_boot),
      .i_supply_ok(i_supply_ok), .i_dq_in(dq_in), .o_busy(busy), .o_done(done), .o_refused(refused),
      .o_rdata(rdata), .o_fl_addr(fl_addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .o_fl_ce_n(ce_n),
      .o_fl_we_n(we_n), .o_fl_oe_n(oe_n), .o_fl_reset_n(fl_rst_n), .o_rst_id_hv_en(id_hv),
      .o_wp_n(wp_n), .o_acc_hv_en(acc_hv));
   fsg_flash_model u_fsg_flash_model (.i_top_boot(i_top_boot), .i_addr(fl_addr), .i_dq(dq_out),
      .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_reset_n(fl_rst_n), .i_id_hv(id_hv),
      .i_wp_n(wp_n), .i_acc_hv(acc_hv), .o_dq(dq_in));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // raise a request for one edge, then wait a bounded time for done
   task automatic go(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
      int n;
      i_op <= op;
      i_addr <= a;
      i_wdata <= d;
      i_req <= 1'b1;
      @(posedge i_ref_clk);
      i_req <= 1'b0;
      // a refusal answers on the taking edge itself, so look before the next edge
      #1;
      n = 0;
      while (done !== 1'b1 && n < 3000)
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      rf = refused;
      if (n >= 3000)
      begin
         err_total++;
         $display("wrong value done expected 1 seen 0");
         stop_test();
      end
   endtask
   task automatic run(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      go(op, a, d);
   endtask
   // read back one word through the sequencer
   task automatic rd_chk(input logic [19:0] a, input logic [15:0] e);
      run(`FSG_OP_READ, a, 16'h0000);
      chk("rdata", {4'h0, e}, {4'h0, rdata});
   endtask
   // a request taken in the first edge after reset is locked out
   task automatic t_lockout();
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      go(`FSG_OP_PROG, 20'h10004, 16'h0000);
      chk("refused", 1, rf);
      rd_chk(20'h10004, 16'hFFFF);
      $display("test lockout ended");
   endtask
   // program, protect, bypass, temporary unprotect, erase
   task automatic t_protect();
      run(`FSG_OP_PROG, 20'h10004, 16'h1234);
      chk("refused", 0, rf);
      rd_chk(20'h10004, 16'h1234);
      chk("wp_n", 0, wp_n);
      u_fsg_flash_model.prot[8'h10] = 1'b1;
      run(`FSG_OP_PROG, 20'h10004, 16'h0000);
      rd_chk(20'h10004, 16'h1234);
      acc_seen = 1'b0;
      run(`FSG_OP_ACCEL_PROG, 20'h10004, 16'h0204);
      rd_chk(20'h10004, 16'h0204);
      chk("acc_seen", 1, acc_seen);
      chk("acc_hv", 0, acc_hv);
      hv_seen = 1'b0;
      run(`FSG_OP_TEMP_UNPROT, 20'h10000, 16'h0000);
      chk("hv_seen", 1, hv_seen);
      chk("id_hv", 0, id_hv);
      u_fsg_flash_model.prot[8'h10] = 1'b0;
      run(`FSG_OP_ERASE, 20'h10000, 16'h0000);
      rd_chk(20'h10004, 16'hFFFF);
      $display("test protect ended");
   endtask
   // outer boot sector of each variant programs with the lock lifted
   task automatic t_boot();
      for (int t = 1; t >= 0; t--)
      begin
         @(posedge i_ref_clk);
         i_top_boot <= t[0];
         run(`FSG_OP_PROG, {(t ? 8'hFF : 8'h00), 12'h008}, 16'h00C3);
         rd_chk({(t ? 8'hFF : 8'h00), 12'h008}, 16'h00C3);
      end
      $display("test boot ended");
   endtask
   // low supply refuses and holds the flash in reset
   task automatic t_supply();
      @(posedge i_ref_clk);
      i_supply_ok <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      run(`FSG_OP_PROG, 20'h20000, 16'h0000);
      chk("refused", 1, rf);
      chk("fl_rst_n", 0, fl_rst_n);
      @(posedge i_ref_clk);
      i_supply_ok <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      rd_chk(20'h20000, 16'hFFFF);
      $display("test supply ended");
   endtask
   initial
   begin
      t_lockout();
      t_protect();
      t_boot();
      t_supply();
      stop_test();
   end
endmodule // tb_top
